// ---- verilog/flash_seq_dev.sv ----
// Flash command sequencer, device end
`default_nettype none
module flash_seq_dev import flash_seq_pkg::*; (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic NRST,
	// Command link
	flash_seq_if.dev LNK,
	// Array operations
	output logic OP_START,
	output logic [7:0] OP_CODE,
	output logic [23:0] OP_ADDR,
	output logic [15:0] OP_COUNT,
	output logic [63:0] OP_WDATA,
	input wire logic OP_DONE,
	input wire logic OP_FAIL,
	input wire logic [63:0] OP_RDATA,
	// Array reads
	output logic ARR_RD_REQ,
	output logic [15:0] ARR_RD_ADDR,
	input wire logic [7:0] ARR_RD_DATA,
	// Mode, security and keys
	input wire logic SPECIAL_MODE,
	input wire logic [1:0] SEC_INIT,
	input wire logic [1:0] PROT_INIT,
	input wire logic KEY_ENABLE,
	input wire logic [63:0] KEY_STORED,
	// Settings out
	output logic [1:0] SEC_STATE,
	output logic [1:0] MARGIN_LEVEL,
	output logic MARGIN_FACTORY,
	output logic [7:0] CLK_DIV
);
	// ==========================================
	// State
	typedef struct packed {
		dstate_e st;
		logic [PARAM_WORDS-1:0][15:0] par;
		logic [2:0] idx;
		logic [7:0] code;
		logic command_complete_flag;
		logic access_error_flag;
		logic protection_violation_flag;
		logic [1:0] verify_result_bits;
		logic [7:0] div;
		logic div_set;
		logic popen;
		logic hdis;
		logic [1:0] sec;
		logic key_lock;
		logic [1:0] margin;
		logic mfact;
		logic init;
		logic op_start;
		logic arr_rd;
		logic [15:0] arr_addr;
		logic rd_valid;
		logic [7:0] rd_data;
		logic [15:0] param_rd;
	} dev_s;
	dev_s s_r;
	dev_s s_nxt;
	logic [7:0] lc;
	logic [23:0] gaddr;
	logic launch;
	logic bad;
	logic secured;
	logic mode_ok;
	logic key_bad;
	logic key_match;
	// ==========================================
	// Launch checks
	always_comb begin
		lc = s_r.par[0][15:8];
		gaddr = {s_r.par[0][7:0], s_r.par[1]};
		secured = (s_r.sec != SEC_UNSEC);
		// Secured special mode only allows the recovery commands
		mode_ok = !(secured && SPECIAL_MODE) || lc == CMD_VFY_ALL || lc == CMD_ERS_ALL ||
			lc == CMD_UNSECURE;
		key_bad = 1'b0;
		for (int i = 1; i <= 4; i++) begin
			if (s_r.par[i] == KEY_BAD_LO || s_r.par[i] == KEY_BAD_HI) begin
				key_bad = 1'b1;
			end
		end
		key_match = ({s_r.par[1], s_r.par[2], s_r.par[3], s_r.par[4]} == KEY_STORED);
		// A launch with errors pending is dropped, so stale errors never mix with new ones
		launch = LNK.wr && LNK.sel == SEL_STATUS && LNK.wdata[ST_COMMAND_COMPLETE_FLAG] && s_r.st == D_IDLE &&
			!s_r.access_error_flag && !s_r.protection_violation_flag;
		bad = !code_known(lc) ||
			!idx_ok(lc, s_r.idx) ||
			(needs_div(lc) && !s_r.div_set) ||
			!mode_ok ||
			(needs_addr(lc) && (gaddr < FLASH_LO || gaddr > FLASH_HI)) ||
			((lc == CMD_VFY_SEC || lc == CMD_PGM) && gaddr[1:0] != 2'h0) ||
			(lc == CMD_KEY && (!KEY_ENABLE || s_r.key_lock || key_bad)) ||
			((lc == CMD_MRG_USER || lc == CMD_MRG_FACT) && s_r.par[1] > MARGIN_MAX);
	end
	// ==========================================
	// Next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.op_start = 1'b0;
		s_nxt.rd_valid = 1'b0;
		if (!s_r.init) begin
			s_nxt.init = 1'b1;
			s_nxt.sec = SEC_INIT;
			s_nxt.popen = PROT_INIT[1];
			s_nxt.hdis = PROT_INIT[0];
		end
		// Error flags clear by writing one
		if (LNK.wr && LNK.sel == SEL_STATUS) begin
			if (LNK.wdata[ST_ACCESS_ERROR_FLAG]) begin
				s_nxt.access_error_flag = 1'b0;
			end
			if (LNK.wdata[ST_PROTECTION_VIOLATION_FLAG]) begin
				s_nxt.protection_violation_flag = 1'b0;
			end
		end
		if (LNK.wr && s_r.st == D_IDLE) begin
			unique case (LNK.sel)
				SEL_INDEX: s_nxt.idx = LNK.wdata[2:0];
				SEL_PARAM: begin
					if (s_r.idx < IDX_5 + 3'h1) begin
						s_nxt.par[s_r.idx] = LNK.wdata;
					end
				end
				SEL_DIV: begin
					s_nxt.div = LNK.wdata[7:0];
					s_nxt.div_set = 1'b1;
				end
				SEL_PROT: begin
					s_nxt.popen = LNK.wdata[PROT_OPEN];
					s_nxt.hdis = LNK.wdata[PROT_HDIS];
				end
				default: ;
			endcase
		end
		unique case (s_r.st)
			D_IDLE: begin
				if (launch) begin
					s_nxt.code = lc;
					s_nxt.verify_result_bits = VERIFY_RESULT_BITS_OK;
					if (bad) begin
						s_nxt.access_error_flag = 1'b1;
					end else if ((lc == CMD_ERS_ALL || lc == CMD_ERS_BLK) && !(s_r.hdis && s_r.popen)) begin
						s_nxt.protection_violation_flag = 1'b1;
					end else begin
						s_nxt.command_complete_flag = 1'b0;
						s_nxt.st = D_RUN;
					end
				end
			end
			D_RUN: begin
				unique case (s_r.code)
					CMD_KEY: begin
						if (key_match) begin
							s_nxt.sec = SEC_UNSEC;
						end else begin
							s_nxt.access_error_flag = 1'b1;
							s_nxt.key_lock = 1'b1;
						end
						s_nxt.command_complete_flag = 1'b1;
						s_nxt.st = D_IDLE;
					end
					CMD_MRG_USER, CMD_MRG_FACT: begin
						s_nxt.margin = s_r.par[1][1:0];
						s_nxt.mfact = (s_r.code == CMD_MRG_FACT);
						s_nxt.command_complete_flag = 1'b1;
						s_nxt.st = D_IDLE;
					end
					default: begin
						s_nxt.op_start = 1'b1;
						s_nxt.st = D_WAIT;
					end
				endcase
			end
			D_WAIT: begin
				if (OP_DONE) begin
					s_nxt.command_complete_flag = 1'b1;
					if (OP_FAIL && s_r.code <= CMD_PGM_ONCE) begin
						s_nxt.verify_result_bits = VERIFY_RESULT_BITS_FAIL;
					end
					if (!OP_FAIL && (s_r.code == CMD_UNSECURE || s_r.code == CMD_ERS_ALL)) begin
						s_nxt.sec = SEC_UNSEC;
					end
					if (s_r.code == CMD_RD_ONCE) begin
						for (int i = 0; i < 4; i++) begin
							s_nxt.par[2 + i] = OP_RDATA[63 - 16 * i -: 16];
						end
					end
					s_nxt.st = D_IDLE;
				end
			end
			default: s_nxt.st = D_IDLE;
		endcase
		// Array reads: one block, so any running command spoils every read
		s_nxt.arr_rd = LNK.rd_req;
		if (LNK.rd_req) begin
			s_nxt.arr_addr = LNK.rd_addr;
		end
		if (s_r.arr_rd) begin
			s_nxt.rd_valid = 1'b1;
			s_nxt.rd_data = s_r.command_complete_flag ? ARR_RD_DATA : INVALID_BYTE;
		end
		s_nxt.param_rd = s_nxt.par[s_nxt.idx < IDX_5 + 3'h1 ? s_nxt.idx : IDX_0];
	end
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			s_r <= '0;
			s_r.st <= D_IDLE;
			s_r.command_complete_flag <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end
	// ==========================================
	// Outputs
	assign LNK.command_complete_flag = s_r.command_complete_flag;
	assign LNK.access_error_flag = s_r.access_error_flag;
	assign LNK.protection_violation_flag = s_r.protection_violation_flag;
	assign LNK.verify_result_bits = s_r.verify_result_bits;
	assign LNK.sec = s_r.sec;
	assign LNK.param_rd = s_r.param_rd;
	assign LNK.rd_valid = s_r.rd_valid;
	assign LNK.rd_data = s_r.rd_data;
	assign OP_START = s_r.op_start;
	assign OP_CODE = s_r.code;
	assign OP_ADDR = {s_r.par[0][7:0], s_r.par[1]};
	assign OP_COUNT = s_r.par[2];
	assign OP_WDATA = {s_r.par[2], s_r.par[3], s_r.par[4], s_r.par[5]};
	assign ARR_RD_REQ = s_r.arr_rd;
	assign ARR_RD_ADDR = s_r.arr_addr;
	assign SEC_STATE = s_r.sec;
	assign MARGIN_LEVEL = s_r.margin;
	assign MARGIN_FACTORY = s_r.mfact;
	assign CLK_DIV = s_r.div;
endmodule
`default_nettype wire

// ---- verilog/flash_seq_pkg.sv ----
// Shared constants, encodings and helpers for the flash command sequencer
`default_nettype none
package flash_seq_pkg;
	// ==========================================
	// Command codes
	localparam logic [7:0] CMD_VFY_ALL = 8'h01;
	localparam logic [7:0] CMD_VFY_BLK = 8'h02;
	localparam logic [7:0] CMD_VFY_SEC = 8'h03;
	localparam logic [7:0] CMD_RD_ONCE = 8'h04;
	localparam logic [7:0] CMD_PGM = 8'h06;
	localparam logic [7:0] CMD_PGM_ONCE = 8'h07;
	localparam logic [7:0] CMD_ERS_ALL = 8'h08;
	localparam logic [7:0] CMD_ERS_BLK = 8'h09;
	localparam logic [7:0] CMD_ERS_SECT = 8'h0A;
	localparam logic [7:0] CMD_UNSECURE = 8'h0B;
	localparam logic [7:0] CMD_KEY = 8'h0C;
	localparam logic [7:0] CMD_MRG_USER = 8'h0D;
	localparam logic [7:0] CMD_MRG_FACT = 8'h0E;
	// ==========================================
	// Write targets on the link
	localparam logic [2:0] SEL_INDEX = 3'h0;
	localparam logic [2:0] SEL_PARAM = 3'h1;
	localparam logic [2:0] SEL_STATUS = 3'h2;
	localparam logic [2:0] SEL_DIV = 3'h3;
	localparam logic [2:0] SEL_PROT = 3'h4;
	// ==========================================
	// Status and protection bit positions, parameter word count and indices
	localparam int ST_COMMAND_COMPLETE_FLAG = 7;
	localparam int ST_ACCESS_ERROR_FLAG = 5;
	localparam int ST_PROTECTION_VIOLATION_FLAG = 4;
	localparam int PROT_OPEN = 7;
	localparam int PROT_HDIS = 5;
	localparam int PARAM_WORDS = 6;
	localparam logic [2:0] IDX_0 = 3'h0;
	localparam logic [2:0] IDX_1 = 3'h1;
	localparam logic [2:0] IDX_2 = 3'h2;
	localparam logic [2:0] IDX_3 = 3'h3;
	localparam logic [2:0] IDX_4 = 3'h4;
	localparam logic [2:0] IDX_5 = 3'h5;
	// ==========================================
	// Array map, security and margin
	localparam logic [23:0] FLASH_LO = 24'h008000;
	localparam logic [23:0] FLASH_HI = 24'h00FFFF;
	localparam logic [7:0] INVALID_BYTE = 8'hFF;
	localparam logic [1:0] SEC_UNSEC = 2'h2;
	localparam logic [15:0] MARGIN_MAX = 16'h0002;
	localparam logic [15:0] KEY_BAD_LO = 16'h0000;
	localparam logic [15:0] KEY_BAD_HI = 16'hFFFF;
	localparam logic [1:0] VERIFY_RESULT_BITS_FAIL = 2'h3;
	localparam logic [1:0] VERIFY_RESULT_BITS_OK = 2'h0;
	// ==========================================
	// State encodings
	typedef enum logic [2:0] {D_IDLE = 3'b001, D_RUN = 3'b010, D_WAIT = 3'b100} dstate_e;
	typedef enum logic [7:0] {
		H_IDLE = 8'b00000001, H_CLR = 8'b00000010, H_IDX = 8'b00000100, H_PAR = 8'b00001000,
		H_GO = 8'b00010000, H_GAP = 8'b00100000, H_WAIT = 8'b01000000, H_RD = 8'b10000000
	} hstate_e;
	// ==========================================
	// Helpers
	function automatic logic code_known(input logic [7:0] c);
		code_known = (c >= CMD_VFY_ALL && c <= CMD_MRG_FACT && c != 8'h05);
	endfunction
	function automatic logic needs_div(input logic [7:0] c);
		needs_div = (c >= CMD_PGM && c <= CMD_UNSECURE);
	endfunction
	function automatic logic needs_addr(input logic [7:0] c);
		needs_addr = (c == CMD_VFY_BLK || c == CMD_VFY_SEC || c == CMD_PGM || c == CMD_ERS_BLK ||
			c == CMD_ERS_SECT);
	endfunction
	function automatic logic idx_ok(input logic [7:0] c, input logic [2:0] i);
		unique case (c)
			CMD_VFY_ALL, CMD_ERS_ALL, CMD_UNSECURE: idx_ok = (i == IDX_0);
			CMD_VFY_SEC: idx_ok = (i == IDX_2);
			CMD_PGM: idx_ok = (i == IDX_3 || i == IDX_5);
			CMD_PGM_ONCE: idx_ok = (i == IDX_5);
			CMD_KEY: idx_ok = (i == IDX_4);
			default: idx_ok = (i == IDX_1);
		endcase
	endfunction
endpackage
`default_nettype wire

// ---- verilog/flash_seq_if.sv ----
// Link between the command issuer and the flash command sequencer
`default_nettype none
interface flash_seq_if;
	// Issuer to sequencer
	logic wr;
	logic [2:0] sel;
	logic [15:0] wdata;
	logic rd_req;
	logic [15:0] rd_addr;
	// Sequencer to issuer
	logic command_complete_flag;
	logic access_error_flag;
	logic protection_violation_flag;
	logic [1:0] verify_result_bits;
	logic [1:0] sec;
	logic [15:0] param_rd;
	logic rd_valid;
	logic [7:0] rd_data;
	modport host (output wr, sel, wdata, rd_req, rd_addr,
		input command_complete_flag, access_error_flag, protection_violation_flag, verify_result_bits, sec, param_rd, rd_valid, rd_data);
	modport dev (input wr, sel, wdata, rd_req, rd_addr,
		output command_complete_flag, access_error_flag, protection_violation_flag, verify_result_bits, sec, param_rd, rd_valid, rd_data);
endinterface
`default_nettype wire

// ---- verilog/flash_seq_host.sv ----
// Command issuer end of the flash sequencer link
`default_nettype none
module flash_seq_host import flash_seq_pkg::*; (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic NRST,
	// Command link
	flash_seq_if.host LNK,
	// Configuration
	input wire logic CFG_DIV_WR,
	input wire logic CFG_PROT_WR,
	input wire logic [15:0] CFG_DATA,
	// Commands
	input wire logic CMD_START,
	input wire logic [2:0] CMD_WORDS,
	input wire logic [95:0] CMD_PARAMS,
	output logic CMD_BUSY,
	output logic CMD_DONE,
	output logic [4:0] CMD_STATUS,
	// Reads
	input wire logic RD_START,
	input wire logic [15:0] RD_ADDR,
	output logic RD_VALID,
	output logic [7:0] RD_DATA
);
	// ==========================================
	// State
	typedef struct packed {
		hstate_e st;
		logic wr;
		logic [2:0] sel;
		logic [15:0] wdata;
		logic rd_req;
		logic [15:0] rd_addr;
		logic [2:0] cnt;
		logic [2:0] last;
		logic [95:0] params;
		logic busy;
		logic done;
		logic [4:0] status;
		logic rvalid;
		logic [7:0] rdata;
		logic div_done;
	} host_s;
	host_s s_r;
	host_s s_nxt;
	logic [7:0] code;
	always_comb begin
		s_nxt = s_r;
		s_nxt.wr = 1'b0;
		s_nxt.rd_req = 1'b0;
		s_nxt.done = 1'b0;
		s_nxt.rvalid = 1'b0;
		code = CMD_PARAMS[15:8];
		unique case (s_r.st)
			H_IDLE: begin
				if (CMD_START) begin
					s_nxt.params = CMD_PARAMS;
					s_nxt.last = CMD_WORDS - 3'h1;
					s_nxt.cnt = 3'h0;
					if (needs_div(code) && !s_r.div_done) begin
						// Divider must come first in any program or erase flow
						s_nxt.done = 1'b1;
						s_nxt.status = 5'h10;
					end else begin
						s_nxt.busy = 1'b1;
						s_nxt.st = (LNK.access_error_flag || LNK.protection_violation_flag) ? H_CLR : H_IDX;
					end
				end else if (RD_START) begin
					s_nxt.rd_req = 1'b1;
					s_nxt.rd_addr = RD_ADDR;
					s_nxt.busy = 1'b1;
					s_nxt.st = H_RD;
				end else if (CFG_DIV_WR || CFG_PROT_WR) begin
					s_nxt.wr = 1'b1;
					s_nxt.sel = CFG_DIV_WR ? SEL_DIV : SEL_PROT;
					s_nxt.wdata = CFG_DATA;
					s_nxt.div_done = s_r.div_done || CFG_DIV_WR;
				end
			end
			H_CLR: begin
				s_nxt.wr = 1'b1;
				s_nxt.sel = SEL_STATUS;
				s_nxt.wdata = 16'h0000;
				s_nxt.wdata[ST_ACCESS_ERROR_FLAG] = 1'b1;
				s_nxt.wdata[ST_PROTECTION_VIOLATION_FLAG] = 1'b1;
				s_nxt.st = H_IDX;
			end
			H_IDX: begin
				s_nxt.wr = 1'b1;
				s_nxt.sel = SEL_INDEX;
				s_nxt.wdata = {13'h0000, s_r.cnt};
				s_nxt.st = H_PAR;
			end
			H_PAR: begin
				s_nxt.wr = 1'b1;
				s_nxt.sel = SEL_PARAM;
				s_nxt.wdata = s_r.params[16 * s_r.cnt +: 16];
				s_nxt.cnt = 3'(s_r.cnt + 3'h1);
				s_nxt.st = (s_r.cnt == s_r.last) ? H_GO : H_IDX;
			end
			H_GO: begin
				// Reads are held off by this machine, so no launch meets a fetch
				s_nxt.wr = 1'b1;
				s_nxt.sel = SEL_STATUS;
				s_nxt.wdata = 16'h0000;
				s_nxt.wdata[ST_COMMAND_COMPLETE_FLAG] = 1'b1;
				s_nxt.st = H_GAP;
			end
			H_GAP: s_nxt.st = H_WAIT;
			H_WAIT: begin
				if (LNK.command_complete_flag) begin
					s_nxt.done = 1'b1;
					s_nxt.busy = 1'b0;
					s_nxt.status = {1'b0, LNK.access_error_flag, LNK.protection_violation_flag, LNK.verify_result_bits};
					s_nxt.st = H_IDLE;
				end
			end
			H_RD: begin
				if (LNK.rd_valid) begin
					s_nxt.rvalid = 1'b1;
					s_nxt.rdata = LNK.rd_data;
					s_nxt.busy = 1'b0;
					s_nxt.st = H_IDLE;
				end
			end
		endcase
	end
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			s_r <= '0;
			s_r.st <= H_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end
	// ==========================================
	// Outputs
	assign LNK.wr = s_r.wr;
	assign LNK.sel = s_r.sel;
	assign LNK.wdata = s_r.wdata;
	assign LNK.rd_req = s_r.rd_req;
	assign LNK.rd_addr = s_r.rd_addr;
	assign CMD_BUSY = s_r.busy;
	assign CMD_DONE = s_r.done;
	assign CMD_STATUS = s_r.status;
	assign RD_VALID = s_r.rvalid;
	assign RD_DATA = s_r.rdata;
endmodule
`default_nettype wire

// ---- bench/flash_command_sequencer_assertions.sv ----
// Link checker for the flash command sequencer
`default_nettype none
module flash_seq_checker import flash_seq_pkg::*; (
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic NRST,
	// Issuer side of the link
	input wire logic wr,
	input wire logic [2:0] sel,
	input wire logic [15:0] wdata,
	input wire logic rd_req,
	// Sequencer side of the link
	input wire logic command_complete_flag,
	input wire logic access_error_flag,
	input wire logic protection_violation_flag,
	input wire logic [1:0] verify_result_bits,
	input wire logic [1:0] sec,
	input wire logic rd_valid,
	input wire logic [7:0] rd_data
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!NRST);
	// ==========================================
	// Shadow of what the sequencer latched while idle
	logic [2:0] idx_r;
	logic [7:0] code_r;
	logic [1:0] up_r;
	wire launch = wr && sel == SEL_STATUS && wdata[ST_COMMAND_COMPLETE_FLAG] && command_complete_flag && !access_error_flag && !protection_violation_flag;
	wire bad_code = code_r == 8'h00 || code_r == 8'h05 || code_r > 8'h0E;
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) begin
			idx_r <= 3'h0;
			code_r <= 8'h00;
			up_r <= 2'h0;
		end else begin
			if (wr && command_complete_flag && sel == SEL_INDEX)
				idx_r <= wdata[2:0];
			if (wr && command_complete_flag && sel == SEL_PARAM && idx_r == IDX_0)
				code_r <= wdata[15:8];
			// Straps land in the first cycles after release, so skip them
			if (up_r != 2'h3)
				up_r <= up_r + 2'h1;
		end
	end
	// ==========================================
	// Assertions
	a_launch_runs: assert property (launch |=> (!command_complete_flag || access_error_flag || protection_violation_flag))
		else $error("Launch neither started nor flagged");
	a_code_refused: assert property (launch && bad_code |=> access_error_flag && command_complete_flag)
		else $error("Unknown code was not refused");
	a_vfy_all_index: assert property (launch && code_r == CMD_VFY_ALL && idx_r != IDX_0 |=> access_error_flag)
		else $error("Verify all with wrong index accepted");
	a_vfy_blk_index: assert property (launch && code_r == CMD_VFY_BLK && idx_r != IDX_1 |=> access_error_flag)
		else $error("Block verify with wrong index accepted");
	a_verify_no_prot: assert property (launch && code_r inside {8'h01, 8'h02, 8'h03} |=> !protection_violation_flag)
		else $error("Verify raised protection violation");
	a_verify_result_bits_cleared: assert property ($fell(command_complete_flag) |-> verify_result_bits == VERIFY_RESULT_BITS_OK)
		else $error("Verify result not cleared at launch");
	a_error_sticky: assert property (access_error_flag && !(wr && sel == SEL_STATUS && wdata[5]) |=> access_error_flag)
		else $error("Access error dropped without a clear");
	a_read_answer: assert property (rd_req |-> ##2 rd_valid)
		else $error("Read answer missing");
	a_read_invalid: assert property (rd_req && !command_complete_flag ##1 !command_complete_flag |=> rd_valid && rd_data == INVALID_BYTE)
		else $error("Read during command gave real data");
	a_sec_unlock: assert property (up_r == 2'h3 && $changed(sec) |-> sec == SEC_UNSEC)
		else $error("Security state moved to a locked value");
	c_launch: cover property (launch);
	c_bad_code: cover property (launch && bad_code);
	c_unsecured: cover property ($changed(sec) && sec == SEC_UNSEC);
endmodule
`default_nettype wire

// ---- bench/flash_command_sequencer_bench.sv ----
// Self-checking bench: issuer and sequencer joined, array played by the bench
`default_nettype none
module flash_command_sequencer_bench import flash_seq_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================
	// Signals
	logic REF_CLK = 1'b0;
	logic NRST = 1'b0;
	logic OP_START, OP_DONE, OP_FAIL, ARR_RD_REQ, SPECIAL_MODE, KEY_ENABLE, MARGIN_FACTORY, done2, fail_next;
	logic CFG_DIV_WR, CFG_PROT_WR, CMD_START, CMD_BUSY, CMD_DONE, RD_START, RD_VALID;
	logic [7:0] OP_CODE, CLK_DIV, ARR_RD_DATA, RD_DATA, cur_code;
	logic [15:0] CFG_DATA, RD_ADDR, ARR_RD_ADDR, OP_COUNT, cur_p1;
	logic [1:0] SEC_INIT, PROT_INIT, SEC_STATE, MARGIN_LEVEL;
	logic [2:0] CMD_WORDS;
	logic [4:0] CMD_STATUS;
	logic [23:0] OP_ADDR;
	logic [95:0] CMD_PARAMS;
	logic [63:0] OP_WDATA, OP_RDATA, KEY_STORED, key_in;
	logic [63:0] q_st[$];
	logic [63:0] q_rd[$];
	int n_errors = 0;
	int n_tests = 0;
	int lat;
	integer seed = 32'hEC5F;
	flash_seq_if lnk();
	flash_seq_if lnk2();
	always #25 REF_CLK = ~REF_CLK;
	// Array byte depends on the address so a stale address shows up
	assign ARR_RD_DATA = ARR_RD_ADDR[7:0] ^ 8'hA5;
	// ==========================================
	// Instances
	flash_seq_host flash_seq_host_inst (.REF_CLK, .NRST, .LNK(lnk), .CFG_DIV_WR, .CFG_PROT_WR, .CFG_DATA, .CMD_START,
		.CMD_WORDS, .CMD_PARAMS, .CMD_BUSY, .CMD_DONE, .CMD_STATUS, .RD_START, .RD_ADDR, .RD_VALID, .RD_DATA);
	flash_seq_dev flash_seq_dev_inst (.REF_CLK, .NRST, .LNK(lnk), .OP_START, .OP_CODE, .OP_ADDR, .OP_COUNT, .OP_WDATA,
		.OP_DONE, .OP_FAIL, .OP_RDATA, .ARR_RD_REQ, .ARR_RD_ADDR, .ARR_RD_DATA, .SPECIAL_MODE, .SEC_INIT, .PROT_INIT,
		.KEY_ENABLE, .KEY_STORED, .SEC_STATE, .MARGIN_LEVEL, .MARGIN_FACTORY, .CLK_DIV);
	// Second sequencer faces the bench directly, which breaks the issuer's duties
	flash_seq_dev flash_seq_dev_inst2 (.REF_CLK, .NRST, .LNK(lnk2), .OP_START(), .OP_CODE(), .OP_ADDR(), .OP_COUNT(),
		.OP_WDATA(), .OP_DONE(done2), .OP_FAIL, .OP_RDATA, .ARR_RD_REQ(), .ARR_RD_ADDR(), .ARR_RD_DATA, .SPECIAL_MODE,
		.SEC_INIT, .PROT_INIT, .KEY_ENABLE, .KEY_STORED, .SEC_STATE(), .MARGIN_LEVEL(), .MARGIN_FACTORY(), .CLK_DIV());
	flash_seq_checker flash_seq_checker_inst (.REF_CLK, .NRST, .wr(lnk.wr), .sel(lnk.sel), .wdata(lnk.wdata),
		.rd_req(lnk.rd_req), .command_complete_flag(lnk.command_complete_flag), .access_error_flag(lnk.access_error_flag), .protection_violation_flag(lnk.protection_violation_flag), .verify_result_bits(lnk.verify_result_bits),
		.sec(lnk.sec), .rd_valid(lnk.rd_valid), .rd_data(lnk.rd_data));
	// ==========================================
	// Tasks
	task automatic chk(input logic [63:0] exp, input logic [63:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: expected %h got %h", $time, exp, got);
		end
	endtask
	task automatic summarize();
		$display("Counts: %0d compares, %0d mismatches", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic wait_for(input logic rd, input int lim);
		int k;
		k = 0;
		while ((rd ? RD_VALID : CMD_DONE) !== 1'b1 && k < lim) begin
			@(negedge REF_CLK);
			k++;
		end
		if (k == lim)
			chk(64'h1, 64'h0);
	endtask
	task automatic rst();
		@(negedge REF_CLK);
		NRST = 1'b0;
		repeat (2) @(negedge REF_CLK);
		NRST = 1'b1;
		repeat (3) @(negedge REF_CLK);
	endtask
	task automatic run(input logic [7:0] code, input logic [2:0] words, input logic [15:0] p1,
		input logic [4:0] exp, input logic fail);
		@(negedge REF_CLK);
		CMD_PARAMS = {$random(seed), $random(seed), $random(seed)};
		CMD_PARAMS[31:0] = {p1, code, 8'h00};
		if (code == CMD_KEY)
			CMD_PARAMS[79:16] = {key_in[15:0], key_in[31:16], key_in[47:32], key_in[63:48]};
		CMD_WORDS = words;
		cur_code = code;
		cur_p1 = p1;
		fail_next = fail;
		OP_RDATA = {$random(seed), $random(seed)};
		q_st.push_back(64'(exp));
		CMD_START = 1'b1;
		@(negedge REF_CLK);
		CMD_START = 1'b0;
		wait_for(1'b0, 400);
		$display("Test of command %h ended", code);
	endtask
	task automatic rd(input logic [15:0] a);
		@(negedge REF_CLK);
		RD_ADDR = a;
		q_rd.push_back(64'(a[7:0] ^ 8'hA5));
		RD_START = 1'b1;
		@(negedge REF_CLK);
		RD_START = 1'b0;
		wait_for(1'b1, 20);
		$display("Test of read %h ended", a);
	endtask
	task automatic cfg(input logic prot, input logic [15:0] d);
		@(negedge REF_CLK);
		CFG_DATA = d;
		CFG_DIV_WR = ~prot;
		CFG_PROT_WR = prot;
		@(negedge REF_CLK);
		{CFG_DIV_WR, CFG_PROT_WR} = 2'b00;
		repeat (4) @(negedge REF_CLK);
	endtask
	task automatic w2(input logic [2:0] s, input logic [15:0] d);
		@(negedge REF_CLK);
		lnk2.sel = s;
		lnk2.wdata = d;
		lnk2.wr = 1'b1;
		@(negedge REF_CLK);
		lnk2.wr = 1'b0;
		lnk2.wdata = ~d;
	endtask
	// ==========================================
	// Result monitor and array responder
	always @(negedge REF_CLK) begin
		if (CMD_DONE === 1'b1)
			chk(q_st.size() > 0 ? q_st.pop_front() : 64'hX, 64'(CMD_STATUS));
		if (RD_VALID === 1'b1)
			chk(q_rd.size() > 0 ? q_rd.pop_front() : 64'hX, 64'(RD_DATA));
	end
	always @(negedge REF_CLK) begin
		if (OP_START === 1'b1) begin
			chk(64'(cur_code), 64'(OP_CODE));
			if (cur_code inside {CMD_VFY_BLK, CMD_VFY_SEC, CMD_PGM, CMD_ERS_BLK, CMD_ERS_SECT})
				chk(64'({8'h00, cur_p1}), 64'(OP_ADDR));
			if (cur_code == CMD_VFY_SEC)
				chk(64'(CMD_PARAMS[47:32]), 64'(OP_COUNT));
			if (cur_code == CMD_PGM)
				chk({CMD_PARAMS[47:32], CMD_PARAMS[63:48], CMD_PARAMS[79:64], CMD_PARAMS[95:80]}, OP_WDATA);
			lat = 1 + ($unsigned($random(seed)) % 6);
			repeat (lat) @(negedge REF_CLK);
			OP_FAIL = fail_next;
			OP_DONE = 1'b1;
			@(negedge REF_CLK);
			OP_DONE = 1'b0;
			OP_FAIL = ~fail_next;
		end
	end
	// ==========================================
	// Main sequence
	initial begin
		{CFG_DIV_WR, CFG_PROT_WR, CMD_START, RD_START, OP_DONE, OP_FAIL, SPECIAL_MODE, done2, fail_next} = '0;
		{CFG_DATA, RD_ADDR, CMD_WORDS, CMD_PARAMS, OP_RDATA, SEC_INIT, PROT_INIT} = '0;
		KEY_ENABLE = 1'b1;
		KEY_STORED = 64'h1357_2468_9ACE_0BDF;
		key_in = KEY_STORED;
		{lnk2.wr, lnk2.sel, lnk2.wdata, lnk2.rd_req, lnk2.rd_addr} = '0;
		rst();
		run(CMD_PGM, 3'h6, 16'h8000, 5'h10, 1'b0);
		cfg(1'b0, 16'h0013);
		chk(64'h13, 64'(CLK_DIV));
		run(8'h05, 3'h1, 16'h0000, 5'h08, 1'b0);
		run(8'h0F, 3'h1, 16'h0000, 5'h08, 1'b0);
		run(CMD_VFY_ALL, 3'h1, 16'h0000, 5'h00, 1'b0);
		run(CMD_VFY_ALL, 3'h1, 16'h0000, 5'h03, 1'b1);
		run(CMD_VFY_ALL, 3'h2, 16'h0000, 5'h08, 1'b0);
		run(CMD_VFY_BLK, 3'h2, 16'h8000, 5'h00, 1'b0);
		run(CMD_VFY_BLK, 3'h2, 16'hFFFC, 5'h03, 1'b1);
		run(CMD_VFY_BLK, 3'h2, 16'h7FFF, 5'h08, 1'b0);
		run(CMD_VFY_BLK, 3'h1, 16'h8000, 5'h08, 1'b0);
		run(CMD_VFY_SEC, 3'h3, 16'h8004, 5'h00, 1'b0);
		run(CMD_RD_ONCE, 3'h2, 16'h0000, 5'h00, 1'b0);
		chk(OP_RDATA, OP_WDATA);
		// Each longword is programmed once only, into erased space
		run(CMD_PGM, 3'h6, 16'h8010, 5'h00, 1'b0);
		run(CMD_PGM_ONCE, 3'h6, 16'h0000, 5'h00, 1'b0);
		run(CMD_ERS_BLK, 3'h2, 16'h8000, 5'h04, 1'b0);
		cfg(1'b1, 16'h0020);
		run(CMD_ERS_ALL, 3'h1, 16'h0000, 5'h04, 1'b0);
		cfg(1'b1, 16'h00A0);
		run(CMD_ERS_BLK, 3'h2, 16'h8000, 5'h00, 1'b0);
		run(CMD_ERS_SECT, 3'h2, 16'h8200, 5'h00, 1'b0);
		SPECIAL_MODE = 1'b1;
		run(CMD_VFY_BLK, 3'h2, 16'h8000, 5'h08, 1'b0);
		run(CMD_VFY_ALL, 3'h1, 16'h0000, 5'h00, 1'b0);
		SPECIAL_MODE = 1'b0;
		run(CMD_KEY, 3'h5, 16'h0000, 5'h00, 1'b0);
		chk(64'(SEC_UNSEC), 64'(SEC_STATE));
		key_in = ~KEY_STORED;
		run(CMD_KEY, 3'h5, 16'h0000, 5'h08, 1'b0);
		key_in = KEY_STORED;
		run(CMD_KEY, 3'h5, 16'h0000, 5'h08, 1'b0);
		run(CMD_MRG_USER, 3'h2, 16'h0002, 5'h00, 1'b0);
		chk(64'h2, 64'({MARGIN_FACTORY, MARGIN_LEVEL}));
		run(CMD_MRG_FACT, 3'h2, 16'h0001, 5'h00, 1'b0);
		chk(64'h5, 64'({MARGIN_FACTORY, MARGIN_LEVEL}));
		run(CMD_MRG_USER, 3'h2, 16'h0003, 5'h08, 1'b0);
		for (int i = 0; i < 3; i++)
			rd(16'($random(seed)));
		// Security byte written by a program command, then the reset
		run(CMD_PGM, 3'h6, 16'hFF7C, 5'h00, 1'b0);
		// Reset between commands: security goes back to the strap value
		rst();
		chk(64'h0, 64'(SEC_STATE));
		cfg(1'b0, 16'h0013);
		cfg(1'b1, 16'h00A0);
		KEY_ENABLE = 1'b0;
		run(CMD_KEY, 3'h5, 16'h0000, 5'h08, 1'b0);
		KEY_ENABLE = 1'b1;
		run(CMD_ERS_ALL, 3'h1, 16'h0000, 5'h00, 1'b0);
		chk(64'(SEC_UNSEC), 64'(SEC_STATE));
		run(CMD_UNSECURE, 3'h1, 16'h0000, 5'h00, 1'b0);
		// Second link: writes and reads while a command runs
		w2(SEL_INDEX, 16'h0000);
		w2(SEL_PARAM, 16'h0100);
		w2(SEL_STATUS, 16'h0080);
		chk(64'h0, 64'(lnk2.command_complete_flag));
		w2(SEL_INDEX, 16'h0003);
		chk(64'h0100, 64'(lnk2.param_rd));
		@(negedge REF_CLK);
		lnk2.rd_req = 1'b1;
		@(negedge REF_CLK);
		lnk2.rd_req = 1'b0;
		for (int k = 0; k < 4 && lnk2.rd_valid !== 1'b1; k++)
			@(negedge REF_CLK);
		chk(64'(INVALID_BYTE), 64'(lnk2.rd_data));
		done2 = 1'b1;
		@(negedge REF_CLK);
		done2 = 1'b0;
		@(negedge REF_CLK);
		chk(64'h1, 64'(lnk2.command_complete_flag));
		// Launch with an error pending must be dropped
		w2(SEL_PARAM, 16'h0500);
		w2(SEL_STATUS, 16'h0080);
		chk(64'h1, 64'(lnk2.access_error_flag));
		w2(SEL_PARAM, 16'h0100);
		w2(SEL_STATUS, 16'h0080);
		chk(64'h1, 64'(lnk2.command_complete_flag));
		w2(SEL_STATUS, 16'h0020);
		chk(64'h0, 64'(lnk2.access_error_flag));
		// Erase launched before the divider was ever written
		w2(SEL_PARAM, 16'h0800);
		w2(SEL_STATUS, 16'h0080);
		chk(64'h1, 64'(lnk2.access_error_flag));
		chk(64'h0, 64'(lnk2.protection_violation_flag));
		$display("Test of second link ended");
		summarize();
	end
	// Whole run takes about five hundred cycles; six thousand cuts a hang short
	initial begin
		repeat (6000) @(posedge REF_CLK);
		n_errors++;
		summarize();
	end
endmodule
`default_nettype wire
